// ---- cps_top.sv ----
// Notes on behaviour
// - Right shift captured word, drop low bits
// - Then left shift, zero filling low bits
// - Optional half-count bit set last
// - Quadrature whole count: 8, 8, offset on
// - Quadrature fractional: 0, 0, offset off
// - Sinusoidal fractional: 0, 4, offset off
// - Fourteen-bit feedback: fractional left shift 6
// - Sinusoidal whole count: 8, 12, offset on
// - Fourteen-bit feedback: whole left shift 14
// - Remote quadrature extended: 0, 13, offset on
// - Remote quadrature plain: 0, 8, offset off
// - Remote sinusoidal: 0, 18, offset on
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module cps_top (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Capture source
  input  wire logic [31:0] capt_word_i,
  input  wire logic        capt_valid_i,
  // Trigger position result
  output logic [31:0]      trig_pos_o,
  output logic             trig_pos_valid_o,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);

  import cps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  cps_aph_t    aph_r, aph_nxt;
  logic        aph_v_r, aph_v_nxt;
  cps_cfg_t    cfg_r, cfg_nxt;
  logic [3:0]  preset_r, preset_nxt;
  logic [31:0] sw_capt_r, sw_capt_nxt;
  logic        sw_strobe_r, sw_strobe_nxt;
  logic [31:0] pos_r, pos_nxt;
  logic        pv_r, pv_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rdy_r, rsp_r;
  logic [31:0] scaled;
  logic [31:0] src_word;
  logic        strobe;
  cps_cfg_t    preset_cfg;
  logic        preset_hit;

  // Take a transfer only when selected, NONSEQ and bus ready
  always_comb begin
    aph_v_nxt = hsel_i && hready_i && (htrans_i == CPS_HTRANS_NONSEQ);
    aph_nxt   = aph_r;
    if (aph_v_nxt) begin
      aph_nxt.write = hwrite_i;
      aph_nxt.addr  = haddr_i[11:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aph_v_r <= 1'b0;
      aph_r   <= '0;
    end else begin
      aph_v_r <= aph_v_nxt;
      aph_r   <= aph_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preset table of recommended settings

  // A preset saves software from knowing each feedback path's bit layout
  always_comb begin
    preset_hit = 1'b1;
    preset_cfg = '0;
    case (preset_r)
      CPS_PS_QD_WHL:   preset_cfg = '{CPS_SH_8, CPS_SH_8,  1'b1};
      CPS_PS_QD_FRC:   preset_cfg = '{CPS_SH_0, CPS_SH_0,  1'b0};
      CPS_PS_SN_FRC:   preset_cfg = '{CPS_SH_0, CPS_SH_4,  1'b0};
      CPS_PS_SN_FRC14: preset_cfg = '{CPS_SH_0, CPS_SH_6,  1'b0};
      CPS_PS_SN_WHL:   preset_cfg = '{CPS_SH_8, CPS_SH_12, 1'b1};
      CPS_PS_SN_WHL14: preset_cfg = '{CPS_SH_8, CPS_SH_14, 1'b1};
      CPS_PS_RQ_EXT:   preset_cfg = '{CPS_SH_0, CPS_SH_13, 1'b1};
      CPS_PS_RQ_NOX:   preset_cfg = '{CPS_SH_0, CPS_SH_8,  1'b0};
      CPS_PS_RS_EXT:   preset_cfg = '{CPS_SH_0, CPS_SH_18, 1'b1};
      default:         preset_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Writing CTRL with preset code 1 to 9 loads that preset a cycle later; else raw fields
  always_comb begin
    cfg_nxt       = cfg_r;
    preset_nxt    = preset_r;
    sw_capt_nxt   = sw_capt_r;
    sw_strobe_nxt = 1'b0;
    if (preset_hit) begin
      cfg_nxt    = preset_cfg;
      preset_nxt = CPS_PS_NONE;
    end
    if (aph_v_r && aph_r.write) begin
      case (aph_r.addr)
        CPS_OFF_CTRL: begin
          cfg_nxt.capture_right_shift_amount =
            hwdata_i[CPS_CTRL_RSH_LSB +: CPS_SW];
          cfg_nxt.capture_left_shift_amount =
            hwdata_i[CPS_CTRL_LSH_LSB +: CPS_SW];
          cfg_nxt.half_count_offset_enable = hwdata_i[CPS_CTRL_HALF];
          preset_nxt = hwdata_i[CPS_CTRL_PRESET_LSB +: 4];
        end
        CPS_OFF_CAPT: begin
          sw_capt_nxt   = hwdata_i;
          sw_strobe_nxt = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r       <= '{CPS_RST_SHIFT, CPS_RST_SHIFT, 1'b0};
      preset_r    <= CPS_PS_NONE;
      sw_capt_r   <= CPS_RST_WORD;
      sw_strobe_r <= 1'b0;
    end else begin
      cfg_r       <= cfg_nxt;
      preset_r    <= preset_nxt;
      sw_capt_r   <= sw_capt_nxt;
      sw_strobe_r <= sw_strobe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaling datapath

  // Hardware strobe wins; the bus capture word is a test path only
  assign strobe   = capt_valid_i || sw_strobe_r;
  assign src_word = capt_valid_i ? capt_word_i : sw_capt_r;

  cps_scaler u_scaler (
    .raw_i (src_word),
    .cfg_i (cfg_r),
    .pos_o (scaled)
  );

  // Result stands until the next strobe
  always_comb begin
    pos_nxt = pos_r;
    pv_nxt  = pv_r;
    if (strobe) begin
      pos_nxt = scaled;
      pv_nxt  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_r <= CPS_RST_WORD;
      pv_r  <= 1'b0;
    end else begin
      pos_r <= pos_nxt;
      pv_r  <= pv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered in the address phase for a zero-wait answer

  always_comb begin
    rdata_nxt = rdata_r;
    if (aph_v_nxt && !hwrite_i) begin
      rdata_nxt = '0;
      case (haddr_i[11:0])
        CPS_OFF_CTRL: begin
          rdata_nxt[CPS_CTRL_RSH_LSB +: CPS_SW] =
            cfg_nxt.capture_right_shift_amount;
          rdata_nxt[CPS_CTRL_LSH_LSB +: CPS_SW] =
            cfg_nxt.capture_left_shift_amount;
          rdata_nxt[CPS_CTRL_HALF] = cfg_nxt.half_count_offset_enable;
        end
        CPS_OFF_CAPT:   rdata_nxt = sw_capt_nxt;
        CPS_OFF_RESULT: rdata_nxt = pos_nxt;
        CPS_OFF_STATUS: rdata_nxt[0] = pv_nxt;
        default:        rdata_nxt = '0;
      endcase
    end
  end

  // Ready and response are flops too, so no output is combinational
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= CPS_RST_WORD;
      rdy_r   <= 1'b1;
      rsp_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rdy_r   <= 1'b1;
      rsp_r   <= 1'b0;
    end
  end

  assign trig_pos_o       = pos_r;
  assign trig_pos_valid_o = pv_r;
  assign hrdata_o         = rdata_r;
  // No wait states and always OKAY
  assign hreadyout_o      = rdy_r;
  assign hresp_o          = rsp_r;

endmodule
`default_nettype wire

// ---- cps_pkg.sv ----
package cps_pkg;

  // Data path widths
  localparam int unsigned CPS_DW = 32;
  localparam int unsigned CPS_SW = 5;

  // Register byte offsets
  localparam logic [11:0] CPS_OFF_CTRL   = 12'h000;
  localparam logic [11:0] CPS_OFF_CAPT   = 12'h004;
  localparam logic [11:0] CPS_OFF_RESULT = 12'h008;
  localparam logic [11:0] CPS_OFF_STATUS = 12'h00c;

  // Control register field positions
  localparam int unsigned CPS_CTRL_RSH_LSB = 0;
  localparam int unsigned CPS_CTRL_LSH_LSB = 8;
  localparam int unsigned CPS_CTRL_HALF    = 16;
  localparam int unsigned CPS_CTRL_PRESET_LSB = 20;

  // Reset values
  localparam logic [CPS_SW-1:0] CPS_RST_SHIFT = 5'h00;
  localparam logic [31:0]       CPS_RST_WORD  = 32'h0000_0000;

  // Preset selector codes
  localparam logic [3:0] CPS_PS_NONE    = 4'h0;
  localparam logic [3:0] CPS_PS_QD_WHL  = 4'h1;
  localparam logic [3:0] CPS_PS_QD_FRC  = 4'h2;
  localparam logic [3:0] CPS_PS_SN_FRC  = 4'h3;
  localparam logic [3:0] CPS_PS_SN_FRC14 = 4'h4;
  localparam logic [3:0] CPS_PS_SN_WHL  = 4'h5;
  localparam logic [3:0] CPS_PS_SN_WHL14 = 4'h6;
  localparam logic [3:0] CPS_PS_RQ_EXT  = 4'h7;
  localparam logic [3:0] CPS_PS_RQ_NOX  = 4'h8;
  localparam logic [3:0] CPS_PS_RS_EXT  = 4'h9;

  // Recommended shift amounts
  localparam logic [CPS_SW-1:0] CPS_SH_0  = 5'h00;
  localparam logic [CPS_SW-1:0] CPS_SH_4  = 5'h04;
  localparam logic [CPS_SW-1:0] CPS_SH_6  = 5'h06;
  localparam logic [CPS_SW-1:0] CPS_SH_8  = 5'h08;
  localparam logic [CPS_SW-1:0] CPS_SH_12 = 5'h0c;
  localparam logic [CPS_SW-1:0] CPS_SH_13 = 5'h0d;
  localparam logic [CPS_SW-1:0] CPS_SH_14 = 5'h0e;
  localparam logic [CPS_SW-1:0] CPS_SH_18 = 5'h12;

  // AHB-Lite encodings
  localparam logic [1:0] CPS_HTRANS_NONSEQ = 2'h2;

  // Scaling settings travel together
  typedef struct packed {
    logic [CPS_SW-1:0] capture_right_shift_amount;
    logic [CPS_SW-1:0] capture_left_shift_amount;
    logic              half_count_offset_enable;
  } cps_cfg_t;

  // One AHB address phase
  typedef struct packed {
    logic        write;
    logic [11:0] addr;
  } cps_aph_t;

endpackage

// ---- cps_scaler.sv ----
`timescale 1ns/10ps
`default_nettype none

module cps_scaler (
  // Raw captured word and settings
  input  wire logic [31:0]       raw_i,
  input  wire cps_pkg::cps_cfg_t cfg_i,
  // Scaled trigger position
  output logic [31:0]            pos_o
);

  import cps_pkg::*;

  logic [31:0] rsh;
  logic [31:0] lsh;

  // Right shift drops low bits, left shift zero-fills and drops high bits
  always_comb begin
    rsh = raw_i >> cfg_i.capture_right_shift_amount;
    lsh = rsh << cfg_i.capture_left_shift_amount;
    pos_o = lsh;
    // Half count bit sits just below the whole count position
    if (cfg_i.half_count_offset_enable &&
        (cfg_i.capture_left_shift_amount != CPS_SH_0)) begin
      pos_o[cfg_i.capture_left_shift_amount - 5'h01] = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- cps_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module cps_monitor (
  // Clock and capture
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] capt_word_i,
  input wire logic        capt_valid_i,
  // Result and bus
  input wire logic [31:0] trig_pos_o,
  input wire logic        trig_pos_valid_o,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o
);
  logic aph;
  logic wr_r, wr_nxt, any_r, any_nxt;
  // Address phase taken by the slave
  assign aph = hsel_i & hready_i & (htrans_i == 2'h2);
  // Flags: any write ends the reset setup, any source may raise valid
  always_comb begin
    wr_nxt = wr_r | (aph & hwrite_i);
    any_nxt = any_r | capt_valid_i | (aph & hwrite_i);
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r <= 1'b0;
      any_r <= 1'b0;
    end else begin
      wr_r <= wr_nxt;
      any_r <= any_nxt;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ready_high: assert property (hreadyout_o)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp_o)
    else $error("hresp not okay");
  a_valid_sticky: assert property (trig_pos_valid_o
    |=> trig_pos_valid_o) else $error("valid dropped");
  a_capt_valid: assert property (capt_valid_i |=> trig_pos_valid_o)
    else $error("valid not set");
  a_pass_thru: assert property (capt_valid_i && !wr_r
    |=> trig_pos_o == $past(capt_word_i)) else $error("no pass through");
  a_pos_hold: assert property (!capt_valid_i && !aph && !$past(aph)
    && !$past(aph, 2) |=> $stable(trig_pos_o)) else $error("pos moved");
  a_result_read: assert property (aph && !hwrite_i && !capt_valid_i
    && haddr_i[11:0] == 12'h008 |=> hrdata_o == trig_pos_o)
    else $error("result read wrong");
  a_no_early: assert property (!any_r |-> !trig_pos_valid_o)
    else $error("early valid");
  c_capt: cover property (capt_valid_i ##1 trig_pos_valid_o);
  c_write: cover property (aph && hwrite_i);
  c_read: cover property (aph && !hwrite_i);
endmodule
bind cps_top cps_monitor mon_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .capt_word_i(capt_word_i), .capt_valid_i(capt_valid_i),
  .trig_pos_o(trig_pos_o), .trig_pos_valid_o(trig_pos_valid_o),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
`default_nettype wire

// ---- cps_enc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cps_enc_model (
  // Clock
  input  wire logic   ref_clk_i,
  // Captured word and strobe
  output logic [31:0] word_o,
  output logic        valid_o
);
  initial begin
    word_o = 32'h0;
    valid_o = 1'b0;
  end
  // Word is scrambled after the strobe so late sampling shows up
  task automatic send(input logic [31:0] w);
    @(posedge ref_clk_i);
    // Any source layout: local word with fraction, or ring word at bit 0
    word_o <= w;
    valid_o <= 1'b1;
    @(posedge ref_clk_i);
    word_o <= ~w;
    valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- cps_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module cps_top_tb_top;
  import cps_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwr = 1'b0;
  logic [1:0]  htr = 2'h0;
  logic [31:0] hadr = 32'h0;
  logic [31:0] hwd = 32'h0;
  logic [31:0] word, pos, hrd, rd, w, e;
  logic        cv, pv, hrdy, hrsp, h;
  logic [4:0]  r, l;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [4:0]  pr_r [1:9] = '{5'h08, 5'h00, 5'h00, 5'h00, 5'h08,
                              5'h08, 5'h00, 5'h00, 5'h00};
  logic [4:0]  pr_l [1:9] = '{5'h08, 5'h00, 5'h04, 5'h06, 5'h0c,
                              5'h0e, 5'h0d, 5'h08, 5'h12};
  logic [1:9]  pr_h = 9'b100011101;
  // 125 MHz clock
  always #4 clk = ~clk;
  cps_top dut_u (.ref_clk_i(clk), .rst_n_i(rst_n), .capt_word_i(word),
    .capt_valid_i(cv), .trig_pos_o(pos), .trig_pos_valid_o(pv),
    .hsel_i(hsel), .haddr_i(hadr), .htrans_i(htr), .hwrite_i(hwr),
    .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy), .hrdata_o(hrd),
    .hreadyout_o(hrdy), .hresp_o(hrsp));
  cps_enc_model enc_u (.ref_clk_i(clk), .word_o(word), .valid_o(cv));
  // Expected scaling: right, left, then the half-count bit
  function automatic logic [31:0] scale(input logic [31:0] x,
                                        input logic [4:0] rs, ls,
                                        input logic hf);
    logic [31:0] v;
    v = (x >> rs) << ls;
    if (hf && ls != 5'h0) v[ls - 5'h1] = 1'b1;
    return v;
  endfunction
  task automatic chk(input logic [31:0] s, x, input string m);
    n_compared++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Single AHB-Lite transfer; waits on ready, never on a fixed count
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htr <= CPS_HTRANS_NONSEQ;
    hwr <= wr;
    hadr <= {20'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard well above the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(63));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    w = $urandom();
    enc_u.send(w);
    @(posedge clk);
    chk(pos, w, "pass through");
    // Every preset code in turn
    for (int i = 1; i <= 9; i++) begin
      bus(1'b1, CPS_OFF_CTRL, 32'(i) << CPS_CTRL_PRESET_LSB);
      w = $urandom();
      enc_u.send(w);
      @(posedge clk);
      e = scale(w, pr_r[i], pr_l[i], pr_h[i]);
      chk(pos, e, "preset");
    end
    // Raw fields, shift of 31 first; odd turns use the bus capture
    for (int i = 0; i < 40; i++) begin
      r = (i == 1) ? 5'h1f : 5'($urandom());
      l = (i == 0) ? 5'h1f : 5'($urandom());
      h = 1'($urandom());
      bus(1'b1, CPS_OFF_CTRL, {15'h0, h, 3'h0, l, 3'h0, r});
      w = $urandom();
      if (i % 2 == 1) bus(1'b1, CPS_OFF_CAPT, w);
      else enc_u.send(w);
      repeat (2) @(posedge clk);
      e = scale(w, r, l, h);
      chk(pos, e, "raw fields");
    end
    bus(1'b0, CPS_OFF_RESULT, 32'h0);
    chk(rd, e, "result read");
    bus(1'b0, CPS_OFF_CTRL, 32'h0);
    chk(rd, {15'h0, h, 3'h0, l, 3'h0, r}, "ctrl read");
    bus(1'b0, CPS_OFF_CAPT, 32'h0);
    chk(rd, w, "capt read");
    bus(1'b0, CPS_OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1, "status");
    bus(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    // Second reset restores the pass-through setup
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    w = $urandom();
    enc_u.send(w);
    @(posedge clk);
    chk(pos, w, "after reset");
    wrap_up();
  end
endmodule
`default_nettype wire
